/* File: src/cjn_exec.sv */
// Decode and execute unit for the compare-and-jump-if-not-equal family
`timescale 1ns/1ns
// Operation
// - Operands differ and first smaller: take branch and set carry.
// - Operands equal: clear carry, no branch, continue sequentially.
// - Direct operand is sampled live, so port values loop until matching.
// - Counter advanced by three first; offset added only when operands differ.
// - Accumulator-immediate form: three bytes, two machine cycles.
// - Register-immediate form: three bytes, two machine cycles.
// - Register form decoded by pattern with low three bits selecting register.
// - Indirect-immediate form: three bytes, two machine cycles.
// - Indirect form decoded by pattern whose lowest bit selects pointer.
// - Target is advanced counter plus sign-extended last instruction byte.
// - Less-than test for carry treats operands as unsigned bytes.
// - Operands never written; only carry and counter are updated.
module cjn_exec import cjn_pkg::*; #(
  parameter int PC_W = CJN_PC_W,
  parameter int CLKS_PER_MCYCLE = CJN_CLKS_PER_MCYCLE
) (
  input  wire logic clk,                       // Core clock
  input  wire logic rst,                       // Async reset, high
  input  wire logic start,                     // Pulse: opcode and bytes valid
  input  wire logic [7:0] opcode,              // First instruction byte
  input  wire logic [7:0] operand_byte,        // Second byte: address or data
  input  wire logic [7:0] offset_byte,         // Third byte: displacement
  input  wire logic [PC_W-1:0] pc_in,          // Address of this instruction
  input  wire logic [7:0] acc,                 // Accumulator value
  input  wire logic [7:0] direct_data,         // Byte at direct_addr, ports live
  input  wire logic [7:0] working_register,    // Value of selected register
  input  wire logic [7:0] ind_ram_data,        // RAM byte at selected pointer
  output logic busy_r,                         // Instruction in progress
  output logic decode_miss_r,                  // Pulse: start with foreign opcode
  output logic [1:0] form_r,                   // Operand form being executed
  output logic [7:0] direct_addr_r,            // Direct address to read
  output logic [2:0] reg_sel_r,                // Working register select
  output logic indirect_pointer_register_r,    // Pointer register select
  output logic done_r,                         // Pulse: results valid
  output logic [PC_W-1:0] program_counter_r,   // New counter value
  output logic pc_we_r,                        // Pulse: load counter
  output logic carry_r,                        // New carry flag
  output logic carry_we_r,                     // Pulse: write carry
  output logic branch_taken_r                  // Pulse: branch was taken
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CLKS_PER_MCYCLE < 1) begin : g_bad_div
    $error("CLKS_PER_MCYCLE must be at least 1");
  end
  if (PC_W < 8) begin : g_bad_pc
    $error("PC_W must be at least 8");
  end

  localparam int DIV_W = (CLKS_PER_MCYCLE > 1) ? $clog2(CLKS_PER_MCYCLE) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLKS_PER_MCYCLE - 1);
  localparam logic [PC_W-1:0] PC_STEP = PC_W'(CJN_INSTR_BYTES);
  localparam logic [1:0] MC_LAST = 2'(CJN_INSTR_MCYCLES - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cjn_state_e state_r, state_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [1:0] mc_r, mc_nxt;
  logic [7:0] first_r, first_nxt;
  logic [7:0] second_r, second_nxt;
  logic [7:0] imm_r, imm_nxt;
  logic [7:0] rel_r, rel_nxt;
  logic [PC_W-1:0] pc_next_r, pc_next_nxt;
  logic [1:0] form_nxt;
  logic [7:0] direct_addr_nxt;
  logic [2:0] reg_sel_nxt;
  logic ptr_nxt;
  logic busy_nxt, miss_nxt, done_nxt, pc_we_nxt, carry_nxt, carry_we_nxt, taken_nxt;
  logic [PC_W-1:0] pc_out_nxt;

  logic mc_tick;
  logic hit;
  logic [1:0] dec_form;
  logic ne, lt;
  logic [PC_W-1:0] target;

  cjn_compare #(.PC_W(PC_W)) cjn_compare_inst (
    .first_op(first_r),
    .second_op(second_r),
    .rel_offset(rel_r),
    .pc_next(pc_next_r),
    .not_equal(ne),
    .less_than(lt),
    .target(target)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    dec_form = CJN_SRC_ACC_IMM;
    if (opcode == CJN_OP_ACC_DIR) begin
      dec_form = CJN_SRC_ACC_DIR;
    end else if (opcode == CJN_OP_ACC_IMM) begin
      dec_form = CJN_SRC_ACC_IMM;
    end else if (opcode[7:3] == CJN_OP_REG_HI) begin
      dec_form = CJN_SRC_REG_IMM;
    end else if (opcode[7:1] == CJN_OP_IND_HI) begin
      dec_form = CJN_SRC_IND_IMM;
    end else begin
      hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Machine-cycle sequencing and execution
  // ----------------------------------------------------------------
  always_comb begin
    mc_tick = (div_r == DIV_LAST);
    state_nxt = state_r;
    div_nxt = mc_tick ? '0 : DIV_W'(div_r + 1'b1);
    mc_nxt = mc_r;
    first_nxt = first_r;
    second_nxt = second_r;
    imm_nxt = imm_r;
    rel_nxt = rel_r;
    pc_next_nxt = pc_next_r;
    form_nxt = form_r;
    direct_addr_nxt = direct_addr_r;
    reg_sel_nxt = reg_sel_r;
    ptr_nxt = indirect_pointer_register_r;
    busy_nxt = busy_r;
    miss_nxt = 1'b0;
    done_nxt = 1'b0;
    pc_we_nxt = 1'b0;
    carry_nxt = carry_r;
    carry_we_nxt = 1'b0;
    taken_nxt = 1'b0;
    pc_out_nxt = program_counter_r;
    case (state_r)
      CJN_ST_IDLE: begin
        div_nxt = '0;
        if (start && hit) begin
          state_nxt = CJN_ST_FETCH;
          busy_nxt = 1'b1;
          mc_nxt = '0;
          form_nxt = dec_form;
          imm_nxt = operand_byte;
          rel_nxt = offset_byte;
          direct_addr_nxt = operand_byte;
          reg_sel_nxt = opcode[CJN_REG_SEL_LSB +: 3];
          ptr_nxt = opcode[CJN_PTR_SEL_BIT];
          pc_next_nxt = pc_in + PC_STEP;
        end else if (start) begin
          miss_nxt = 1'b1;
        end
      end
      CJN_ST_FETCH: begin
        // Operands taken at the end of the first machine cycle so a port reads live
        if (mc_tick) begin
          case (form_r)
            CJN_SRC_ACC_DIR: begin
              first_nxt = acc;
              second_nxt = direct_data;
            end
            CJN_SRC_ACC_IMM: begin
              first_nxt = acc;
              second_nxt = imm_r;
            end
            CJN_SRC_REG_IMM: begin
              first_nxt = working_register;
              second_nxt = imm_r;
            end
            default: begin
              first_nxt = ind_ram_data;
              second_nxt = imm_r;
            end
          endcase
          mc_nxt = 2'(mc_r + 1'b1);
          state_nxt = CJN_ST_EXEC;
        end
      end
      CJN_ST_EXEC: begin
        if (mc_tick && mc_r == MC_LAST) begin
          // Only carry and counter are driven; operands stay untouched
          state_nxt = CJN_ST_IDLE;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          pc_we_nxt = 1'b1;
          carry_we_nxt = 1'b1;
          carry_nxt = ne & lt;
          taken_nxt = ne;
          pc_out_nxt = ne ? target : pc_next_r;
        end else if (mc_tick) begin
          mc_nxt = 2'(mc_r + 1'b1);
        end
      end
      default: begin
        state_nxt = CJN_ST_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= CJN_ST_IDLE;
      div_r <= '0;
      mc_r <= '0;
      first_r <= CJN_BYTE_RST;
      second_r <= CJN_BYTE_RST;
      imm_r <= CJN_BYTE_RST;
      rel_r <= CJN_BYTE_RST;
      pc_next_r <= '0;
      form_r <= CJN_SRC_ACC_DIR;
      direct_addr_r <= CJN_BYTE_RST;
      reg_sel_r <= CJN_SEL_RST;
      indirect_pointer_register_r <= 1'b0;
      busy_r <= 1'b0;
      decode_miss_r <= 1'b0;
      done_r <= 1'b0;
      pc_we_r <= 1'b0;
      carry_r <= 1'b0;
      carry_we_r <= 1'b0;
      branch_taken_r <= 1'b0;
      program_counter_r <= '0;
    end else begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      mc_r <= mc_nxt;
      first_r <= first_nxt;
      second_r <= second_nxt;
      imm_r <= imm_nxt;
      rel_r <= rel_nxt;
      pc_next_r <= pc_next_nxt;
      form_r <= form_nxt;
      direct_addr_r <= direct_addr_nxt;
      reg_sel_r <= reg_sel_nxt;
      indirect_pointer_register_r <= ptr_nxt;
      busy_r <= busy_nxt;
      decode_miss_r <= miss_nxt;
      done_r <= done_nxt;
      pc_we_r <= pc_we_nxt;
      carry_r <= carry_nxt;
      carry_we_r <= carry_we_nxt;
      branch_taken_r <= taken_nxt;
      program_counter_r <= pc_out_nxt;
    end
  end
endmodule // cjn_exec

/* File: shared/cjn_pkg.sv */
// Package with opcodes, form codes, states and timing constants for the compare-jump block
package cjn_pkg;
  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] CJN_OP_ACC_IMM = 8'hB4;
  localparam logic [7:0] CJN_OP_ACC_DIR = 8'hB5;
  localparam logic [6:0] CJN_OP_IND_HI = 7'h5B;
  localparam logic [4:0] CJN_OP_REG_HI = 5'h17;
  localparam int CJN_REG_SEL_LSB = 0;
  localparam int CJN_PTR_SEL_BIT = 0;

  // ----------------------------------------------------------------
  // Instruction shape and timing
  // ----------------------------------------------------------------
  localparam int CJN_INSTR_BYTES = 3;
  localparam int CJN_INSTR_MCYCLES = 2;
  localparam int CJN_CLKS_PER_MCYCLE = 12;
  localparam int CJN_PC_W = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CJN_SRC_ACC_DIR = 2'h0,
    CJN_SRC_ACC_IMM = 2'h1,
    CJN_SRC_REG_IMM = 2'h2,
    CJN_SRC_IND_IMM = 2'h3
  } cjn_form_e;

  typedef enum logic [1:0] {
    CJN_ST_IDLE = 2'h0,
    CJN_ST_FETCH = 2'h1,
    CJN_ST_EXEC = 2'h2
  } cjn_state_e;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CJN_BYTE_RST = 8'h00;
  localparam logic [2:0] CJN_SEL_RST = 3'h0;
endpackage : cjn_pkg

/* File: src/cjn_compare.sv */
// Unsigned compare and relative branch target for the compare-jump block
`timescale 1ns/1ns
module cjn_compare import cjn_pkg::*; #(
  parameter int PC_W = CJN_PC_W
) (
  input  wire logic [7:0] first_op,      // Left operand
  input  wire logic [7:0] second_op,     // Right operand
  input  wire logic [7:0] rel_offset,    // Signed displacement byte
  input  wire logic [PC_W-1:0] pc_next,  // Already advanced counter
  output logic not_equal,                // Operands differ
  output logic less_than,                // Left below right
  output logic [PC_W-1:0] target         // Branch destination
);
  logic [PC_W-1:0] rel_ext;

  always_comb begin
    not_equal = (first_op != second_op);
    // Plain logic vectors compare unsigned
    less_than = (first_op < second_op);
    rel_ext = {{(PC_W-8){rel_offset[7]}}, rel_offset};
    // Wraps modulo the counter width, as a real core does
    target = pc_next + rel_ext;
  end
endmodule // cjn_compare

/* File: tb/cjn_exec_monitor.sv */
// Port checker for the compare-jump execute unit
`timescale 1ns/1ns
module cjn_exec_monitor import cjn_pkg::*; #(
  parameter int PC_W = CJN_PC_W,
  parameter int CLKS_PER_MCYCLE = CJN_CLKS_PER_MCYCLE
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset
  input wire logic start, // Start pulse
  input wire logic [7:0] opcode, // First byte
  input wire logic [PC_W-1:0] pc_in, // Instruction address
  input wire logic busy_r, // In progress
  input wire logic decode_miss_r, // Foreign opcode
  input wire logic [1:0] form_r, // Operand form
  input wire logic [2:0] reg_sel_r, // Register select
  input wire logic done_r, // Results valid
  input wire logic [PC_W-1:0] program_counter_r, // New counter
  input wire logic pc_we_r, // Counter load
  input wire logic carry_r, // New carry
  input wire logic carry_we_r, // Carry write
  input wire logic branch_taken_r // Branch taken
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Sampled one edge after the registered done
  localparam int LAT = 2 * CLKS_PER_MCYCLE + 1;
  wire logic take = start && !busy_r;
  wire logic fam = opcode[7:4] == 4'hB && opcode[3:2] != 2'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_done_latency: assert property (take && fam |-> ##LAT done_r)
    else $error("done not at two machine cycles");
  a_busy_span: assert property (take && fam |=> busy_r)
    else $error("busy not raised on accept");
  // Busy may only fall together with done, so the span is exact
  a_busy_hold: assert property ($fell(busy_r) |-> done_r)
    else $error("busy dropped early");
  a_done_clean: assert property (
    done_r |-> !busy_r && pc_we_r && carry_we_r && $past(busy_r))
    else $error("done pulses inconsistent");
  a_write_gated: assert property (pc_we_r || carry_we_r |-> done_r)
    else $error("write strobe outside done");
  a_branch_done: assert property (branch_taken_r |-> done_r)
    else $error("branch without done");
  a_seq_pc: assert property (
    done_r && !branch_taken_r |-> program_counter_r == PC_W'($past(pc_in, LAT) + 3))
    else $error("sequential counter wrong");
  a_equal_carry: assert property (done_r && !branch_taken_r |-> !carry_r)
    else $error("carry set on equal");
  a_form_reg: assert property (take && opcode[7:3] == 5'h17 |=>
    form_r == 2'h2 && reg_sel_r == 3'($past(opcode)))
    else $error("register form decode wrong");
  a_form_ind: assert property (take && opcode[7:1] == 7'h5B |=> form_r == 2'h3)
    else $error("indirect form decode wrong");
  a_miss_only: assert property (take && !fam |-> ##[1:2] decode_miss_r && !busy_r)
    else $error("foreign opcode not flagged");

  c_branch: cover property (done_r && branch_taken_r && carry_r);
  c_equal: cover property (done_r && !branch_taken_r);
  c_miss: cover property (decode_miss_r);
endmodule // cjn_exec_monitor

/* File: tb/cjn_exec_tb.sv */
// Self-checking bench for the compare-jump execute unit
`timescale 1ns/1ns
module cjn_exec_tb import cjn_pkg::*;;
  localparam int N = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00, operand_byte = 8'h00, offset_byte = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic [7:0] acc = 8'h00, direct_data = 8'h00, working_register = 8'h00, ind_ram_data = 8'h00;
  logic busy_r, decode_miss_r, indirect_pointer_register_r, done_r, pc_we_r, carry_r;
  logic carry_we_r, branch_taken_r;
  logic [1:0] form_r;
  logic [7:0] direct_addr_r;
  logic [2:0] reg_sel_r;
  logic [15:0] program_counter_r;
  int miscompares = 0;
  int samples_checked = 0;

  always #4 clk = ~clk;

  cjn_exec #(.PC_W(16), .CLKS_PER_MCYCLE(N)) cjn_exec_inst (.clk(clk), .rst(rst),
    .start(start), .opcode(opcode), .operand_byte(operand_byte), .offset_byte(offset_byte),
    .pc_in(pc_in), .acc(acc), .direct_data(direct_data), .working_register(working_register),
    .ind_ram_data(ind_ram_data), .busy_r(busy_r), .decode_miss_r(decode_miss_r),
    .form_r(form_r), .direct_addr_r(direct_addr_r), .reg_sel_r(reg_sel_r),
    .indirect_pointer_register_r(indirect_pointer_register_r), .done_r(done_r),
    .program_counter_r(program_counter_r), .pc_we_r(pc_we_r), .carry_r(carry_r),
    .carry_we_r(carry_we_r), .branch_taken_r(branch_taken_r));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Unused sources carry the inverse so a wrong select shows
  task automatic run(input logic [7:0] op, f, s, off, input logic [15:0] pc);
    logic [15:0] npc;
    logic dir;
    logic [1:0] frm;
    dir = (op == 8'hB5);
    frm = op[3] ? CJN_SRC_REG_IMM : CJN_SRC_IND_IMM;
    if (!op[3] && op[2:1] != 2'h3)
      frm = op[0] ? CJN_SRC_ACC_DIR : CJN_SRC_ACC_IMM;
    npc = pc + 16'h0003;
    if (f != s)
      npc = npc + {{8{off[7]}}, off};
    @(negedge clk);
    opcode = op;
    operand_byte = dir ? 8'h90 : s;
    offset_byte = off;
    pc_in = pc;
    acc = (op[7:1] == 7'h5A) ? f : ~f;
    working_register = op[3] ? f : ~f;
    ind_ram_data = (op[7:1] == 7'h5B) ? f : ~f;
    direct_data = ~s;
    start = 1'b1;
    @(negedge clk);
    chk("busy", 1'b1, busy_r);
    chk("form", {14'h0, frm}, form_r);
    if (op[3])
      chk("reg sel", {13'h0, op[2:0]}, reg_sel_r);
    if (op[7:1] == 7'h5B)
      chk("pointer", op[0], indirect_pointer_register_r);
    if (dir)
      chk("address", 16'h0090, direct_addr_r);
    // Port settles only after accept; a latched-early read would miss it
    direct_data = dir ? s : ~s;
    // Start held while busy must be ignored
    opcode = 8'h00;
    @(negedge clk);
    start = 1'b0;
    for (int i = 0; i < 20 && done_r !== 1'b1; i++)
      @(negedge clk);
    chk("done", 1'b1, done_r);
    chk("pc", npc, program_counter_r);
    chk("pc write", 1'b1, pc_we_r);
    chk("carry", f < s, carry_r);
    chk("carry write", 1'b1, carry_we_r);
    chk("branch", f != s, branch_taken_r);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reg();
    for (int r = 0; r < 8; r++)
      run(8'hB8 | 8'(r), 8'h56, 8'h60, 8'h10, 16'h0100);
    run(8'hBF, 8'h70, 8'h60, 8'hF0, 16'h0200);
  endtask

  task automatic t_port();
    run(8'hB5, 8'h34, 8'h35, 8'hFD, 16'h0300);
    run(8'hB5, 8'h34, 8'h34, 8'hFD, 16'h0300);
  endtask

  task automatic t_acc();
    run(8'hB4, 8'hC0, 8'h40, 8'h80, 16'h0010);
    run(8'hB4, 8'h01, 8'hFF, 8'h7F, 16'hFFF0);
  endtask

  task automatic t_ind();
    run(8'hB6, 8'h12, 8'h12, 8'h05, 16'h0400);
    run(8'hB7, 8'h11, 8'h12, 8'h05, 16'h0400);
  endtask

  task automatic t_miss();
    @(negedge clk);
    opcode = 8'hA5;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk("idle busy", 1'b0, busy_r);
    chk("miss", 1'b1, decode_miss_r);
    @(negedge clk);
    chk("miss pulse", 1'b0, decode_miss_r);
    chk("no done", 1'b0, done_r);
  endtask

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reg();
    t_port();
    t_acc();
    t_ind();
    t_miss();
    complete_run();
  end

  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
endmodule // cjn_exec_tb

bind cjn_exec cjn_exec_monitor #(.PC_W(PC_W), .CLKS_PER_MCYCLE(CLKS_PER_MCYCLE)) mon_inst (
  .clk(clk), .rst(rst), .start(start), .opcode(opcode), .pc_in(pc_in), .busy_r(busy_r),
  .decode_miss_r(decode_miss_r), .form_r(form_r), .reg_sel_r(reg_sel_r), .done_r(done_r),
  .program_counter_r(program_counter_r), .pc_we_r(pc_we_r), .carry_r(carry_r),
  .carry_we_r(carry_we_r), .branch_taken_r(branch_taken_r));
